// [stc_config_map.sv]
// sensor trim configuration bank with Avalon-MM slave and trim outputs
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ps
// ============================================================
// ============================================================
module stc_config_map
  import stc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              srst,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  output logic [1:0]             avs_response,
  // offset and sensitivity drift trims
  output logic [8:0]             offset_drift_code,
  output logic [8:0]             sens_drift_code,
  output logic                   drift_range_bit,
  output logic                   wide_drift_range,
  output logic                   narrow_drift_range,
  // detector one
  output logic                   det_one_polarity,
  output logic                   det_one_disable,
  output logic                   det_one_enable,
  output logic                   det_one_direction,
  output logic                   det_one_thresh_source,
  output logic [4:0]             det_one_thresh_code,
  output logic [1:0]             det_one_hyst_code,
  // detector two
  output logic                   det_two_polarity,
  output logic                   det_two_disable,
  output logic                   det_two_enable,
  output logic                   det_two_direction,
  output logic [4:0]             det_two_thresh_code,
  output logic [1:0]             det_two_hyst_code,
  // output reference and gain
  output logic [8:0]             out_ref_code,
  output logic                   out_ref_saturated,
  output logic [4:0]             gain_code,
  output logic                   gain_high_second,
  // measurement mode
  output logic                   gnd_pin_enable,
  output logic                   input_swap,
  output logic                   temp_sensor_select,
  output logic [1:0]             filter_setting,
  output logic                   filter_enable,
  output logic [1:0]             supply_drive_setting,
  output logic                   sample_rate_bit,
  output logic                   config_conflict
);

  // ============================================================
  // elaboration check: the status word at 20h needs six address bits
  if (ADDR_W < 6) begin : g_addr_w_check
    $error("ADDR_W too small for register map");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACK  = 3'b010,
    ST_DONE = 3'b100
  } stc_bus_t;

  // ============================================================
  // helpers
  function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic [7:0] mask);
    merge_byte = (old_v & ~mask) | (new_v & mask);
  endfunction : merge_byte

  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    addr_is = (a == ADDR_W'(off));
  endfunction : addr_is

  // 9-bit trim field: sign or range bit sits in bit0 of the high byte
  function automatic logic [8:0] join9(input logic [7:0] hi, input logic [7:0] lo);
    join9 = {hi[0], lo};
  endfunction : join9

  // ============================================================
  // storage
  logic [7:0] offset_a_q, offset_b_q, sens_a_q, sens_b_q;
  logic [7:0] det1_q, det2_q, hyst_q, ref_hi_q, ref_lo_q;
  logic [7:0] gain_q, meas_q, range_q;
  stc_bus_t   bus_q;
  logic [31:0] rdata_d;
  logic        hit_d;
  logic        wr_go;
  logic [7:0]  wb;
  logic [7:0]  status_d;

  assign wr_go = (bus_q == ST_IDLE) && avs_write && avs_byteenable[0];
  assign wb    = avs_writedata[7:0];

  // ============================================================
  // bus handshake
  // bus state: answer one cycle after request, waitrequest high while idle;
  // a request still held in the two busy states is not taken again
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bus_q <= ST_IDLE;
    end else begin
      case (bus_q)
        ST_IDLE: begin
          if (avs_read || avs_write) begin
            bus_q <= ST_ACK;
          end
        end
        ST_ACK:  bus_q <= ST_DONE;
        ST_DONE: bus_q <= ST_IDLE;
        default: bus_q <= ST_IDLE;
      endcase
    end
  end

  // waitrequest drops for exactly the one acknowledge cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((bus_q == ST_IDLE) && (avs_read || avs_write));
    end
  end

  // ============================================================
  // register store
  // register writes; only lane 0 carries data, upper bits ignored;
  // a write with lane 0 off is acknowledged but changes nothing
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      offset_a_q <= RST_BYTE;
      offset_b_q <= RST_BYTE;
      sens_a_q   <= RST_BYTE;
      sens_b_q   <= RST_BYTE;
      det1_q     <= RST_BYTE;
      det2_q     <= RST_BYTE;
      hyst_q     <= RST_BYTE;
      ref_hi_q   <= RST_BYTE;
      ref_lo_q   <= RST_BYTE;
      gain_q     <= RST_BYTE;
      meas_q     <= RST_BYTE;
      range_q    <= RST_BYTE;
    end else if (wr_go) begin
      // unassigned bits masked to zero so reads stay clean
      if (addr_is(avs_address, OFF_OFFSET_DRIFT_A)) begin
        offset_a_q <= merge_byte(offset_a_q, wb, MASK_BIT0);
      end else if (addr_is(avs_address, OFF_OFFSET_DRIFT_B)) begin
        offset_b_q <= merge_byte(offset_b_q, wb, MASK_FULL);
      end else if (addr_is(avs_address, OFF_SENS_DRIFT_A)) begin
        sens_a_q <= merge_byte(sens_a_q, wb, MASK_BIT0);
      end else if (addr_is(avs_address, OFF_SENS_DRIFT_B)) begin
        sens_b_q <= merge_byte(sens_b_q, wb, MASK_FULL);
      end else if (addr_is(avs_address, OFF_DET_ONE_SETUP)) begin
        det1_q <= merge_byte(det1_q, wb, MASK_FULL);
      end else if (addr_is(avs_address, OFF_DET_TWO_SETUP)) begin
        det2_q <= merge_byte(det2_q, wb, MASK_FULL);
      end else if (addr_is(avs_address, OFF_DET_HYST)) begin
        hyst_q <= merge_byte(hyst_q, wb, MASK_HYST);
      end else if (addr_is(avs_address, OFF_OUT_REF_HIGH)) begin
        ref_hi_q <= merge_byte(ref_hi_q, wb, MASK_BIT0);
      end else if (addr_is(avs_address, OFF_OUT_REF_LOW)) begin
        ref_lo_q <= merge_byte(ref_lo_q, wb, MASK_FULL);
      end else if (addr_is(avs_address, OFF_GAIN_SELECT)) begin
        gain_q <= merge_byte(gain_q, wb, MASK_GAIN);
      end else if (addr_is(avs_address, OFF_MEAS_SETUP)) begin
        meas_q <= merge_byte(meas_q, wb, MASK_FULL);
      end else if (addr_is(avs_address, OFF_DRIFT_RANGE)) begin
        range_q <= merge_byte(range_q, wb, MASK_BIT0);
      end
    end
  end

  // ============================================================
  // readback
  // status: forbidden gain code, rate/sensor clash, filter active
  always_comb begin
    status_d = 8'h00;
    status_d[ST_GAIN_BAD] = gain_q[3:0] > GAIN_CODE_MAX;
    status_d[ST_RATE_BAD] = (meas_q[MEAS_SF_BIT] == RATE_1KHZ) &&
                            (meas_q[MEAS_TMP_BIT] == TEMP_EXTERNAL);
    status_d[ST_FILT_ON]  = meas_q[4:3] != FILTER_OFF;
  end

  // read mux; unmapped addresses read zero with slave-error response
  // status at 20h is read-only, a write to it is dropped
  always_comb begin
    rdata_d = 32'h0000_0000;
    hit_d   = 1'b1;
    if (addr_is(avs_address, OFF_OFFSET_DRIFT_A)) begin
      rdata_d[7:0] = offset_a_q;
    end else if (addr_is(avs_address, OFF_OFFSET_DRIFT_B)) begin
      rdata_d[7:0] = offset_b_q;
    end else if (addr_is(avs_address, OFF_SENS_DRIFT_A)) begin
      rdata_d[7:0] = sens_a_q;
    end else if (addr_is(avs_address, OFF_SENS_DRIFT_B)) begin
      rdata_d[7:0] = sens_b_q;
    end else if (addr_is(avs_address, OFF_DET_ONE_SETUP)) begin
      rdata_d[7:0] = det1_q;
    end else if (addr_is(avs_address, OFF_DET_TWO_SETUP)) begin
      rdata_d[7:0] = det2_q;
    end else if (addr_is(avs_address, OFF_DET_HYST)) begin
      rdata_d[7:0] = hyst_q;
    end else if (addr_is(avs_address, OFF_OUT_REF_HIGH)) begin
      rdata_d[7:0] = ref_hi_q;
    end else if (addr_is(avs_address, OFF_OUT_REF_LOW)) begin
      rdata_d[7:0] = ref_lo_q;
    end else if (addr_is(avs_address, OFF_GAIN_SELECT)) begin
      rdata_d[7:0] = gain_q;
    end else if (addr_is(avs_address, OFF_MEAS_SETUP)) begin
      rdata_d[7:0] = meas_q;
    end else if (addr_is(avs_address, OFF_DRIFT_RANGE)) begin
      rdata_d[7:0] = range_q;
    end else if (addr_is(avs_address, OFF_STATUS)) begin
      rdata_d[7:0] = status_d;
    end else begin
      hit_d = 1'b0;
    end
  end

  // read data and response registered with the acknowledge
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      avs_readdata <= 32'h0000_0000;
      avs_response <= RESP_OKAY;
    end else if ((bus_q == ST_IDLE) && (avs_read || avs_write)) begin
      avs_readdata <= avs_read ? rdata_d : 32'h0000_0000;
      avs_response <= hit_d ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ============================================================
  // trim outputs, one flop stage from the stored bytes;
  // values follow the store from reset onward with no command
  // a write therefore reaches the trims in the cycle after its acknowledge

  // drift trims: 9-bit codes keep the sign bit on top
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      offset_drift_code  <= 9'h000;
      sens_drift_code    <= 9'h000;
      drift_range_bit    <= 1'b0;
      wide_drift_range   <= 1'b0;
      narrow_drift_range <= 1'b1;
    end else begin
      offset_drift_code  <= join9(offset_a_q, offset_b_q);
      sens_drift_code    <= join9(sens_a_q, sens_b_q);
      drift_range_bit    <= range_q[0];
      wide_drift_range   <= range_q[0];
      narrow_drift_range <= !range_q[0];
    end
  end

  // reference level and gain; the analog side does the clamping,
  // the saturation flag only reports it
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      out_ref_code      <= 9'h000;
      out_ref_saturated <= 1'b0;
      gain_code         <= 5'h00;
      gain_high_second  <= 1'b1;
    end else begin
      out_ref_code      <= join9(ref_hi_q, ref_lo_q);
      out_ref_saturated <= ref_lo_q >= REF_SAT_CODE;
      gain_code         <= gain_q[4:0];
      // one flag serves both ranges: 3x or 2.352x when high
      gain_high_second  <= !gain_q[GAIN_G2_BIT];
    end
  end

  // ============================================================
  // detector one controls; disable is stored, enable is its inverse
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      det_one_polarity      <= 1'b0;
      det_one_disable       <= 1'b0;
      det_one_enable        <= 1'b1;
      det_one_direction     <= 1'b0;
      det_one_thresh_source <= 1'b0;
      det_one_thresh_code   <= 5'h00;
      det_one_hyst_code     <= 2'h0;
    end else begin
      det_one_polarity      <= det1_q[DET_POL_BIT];
      det_one_disable       <= det1_q[DET_DIS_BIT];
      det_one_enable        <= !det1_q[DET_DIS_BIT];
      det_one_direction     <= det1_q[DET_DIR_BIT];
      det_one_thresh_source <= hyst_q[HYST_SRC_BIT];
      det_one_thresh_code   <= det1_q[4:0];
      det_one_hyst_code     <= hyst_q[1:0];
    end
  end

  // detector two controls; no source select, the shared pin serves detector one
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      det_two_polarity    <= 1'b0;
      det_two_disable     <= 1'b0;
      det_two_enable      <= 1'b1;
      det_two_direction   <= 1'b0;
      det_two_thresh_code <= 5'h00;
      det_two_hyst_code   <= 2'h0;
    end else begin
      det_two_polarity    <= det2_q[DET_POL_BIT];
      det_two_disable     <= det2_q[DET_DIS_BIT];
      det_two_enable      <= !det2_q[DET_DIS_BIT];
      det_two_direction   <= det2_q[DET_DIR_BIT];
      det_two_thresh_code <= det2_q[4:0];
      det_two_hyst_code   <= hyst_q[3:2];
    end
  end

  // ============================================================
  // measurement mode fields, passed through as stored
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      gnd_pin_enable       <= 1'b0;
      input_swap           <= 1'b0;
      temp_sensor_select   <= 1'b0;
      filter_setting       <= 2'h0;
      supply_drive_setting <= 2'h0;
      sample_rate_bit      <= 1'b0;
    end else begin
      gnd_pin_enable       <= meas_q[MEAS_GND_BIT];
      input_swap           <= meas_q[MEAS_SWP_BIT];
      temp_sensor_select   <= meas_q[MEAS_TMP_BIT];
      filter_setting       <= meas_q[4:3];
      supply_drive_setting <= meas_q[2:1];
      sample_rate_bit      <= meas_q[MEAS_SF_BIT];
    end
  end

  // derived flags; a clash is flagged, not blocked,
  // so the stored byte stays as written
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      filter_enable   <= 1'b0;
      config_conflict <= 1'b0;
    end else begin
      filter_enable   <= status_d[ST_FILT_ON];
      config_conflict <= status_d[ST_RATE_BAD] | status_d[ST_GAIN_BAD];
    end
  end

endmodule : stc_config_map

// [stc_config_map_sva.sv]
// checker: bus timing and derived trim flags of the configuration bank
`timescale 1ns/1ps
module stc_config_map_sva
  import stc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock, reset and bus
  input wire logic              clk_sys,
  input wire logic              srst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_writedata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic              avs_waitrequest,
  // trim outputs
  input wire logic              wide_drift_range,
  input wire logic              narrow_drift_range,
  input wire logic              det_one_disable,
  input wire logic              det_one_enable,
  input wire logic [8:0]        out_ref_code,
  input wire logic              out_ref_saturated,
  input wire logic [4:0]        gain_code,
  input wire logic              gain_high_second,
  input wire logic              gnd_pin_enable,
  input wire logic              input_swap,
  input wire logic              temp_sensor_select,
  input wire logic [1:0]        filter_setting,
  input wire logic              filter_enable,
  input wire logic [1:0]        supply_drive_setting,
  input wire logic              sample_rate_bit,
  input wire logic              config_conflict
);
  // ============================================================
  // properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  // ack lasts one cycle, then waitrequest stays high for the next two cycles
  a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest [*2])
    else $error("waitrequest low longer than one cycle");
  a_ack_has_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("ack without a request");
  // the measurement byte appears whole on the mode outputs
  a_meas_store: assert property (!avs_waitrequest && avs_write && avs_byteenable[0] &&
    avs_address == ADDR_W'(OFF_MEAS_SETUP) |=> {gnd_pin_enable, input_swap,
    temp_sensor_select, filter_setting, supply_drive_setting, sample_rate_bit}
    == $past(avs_writedata[7:0]))
    else $error("measurement byte not applied");
  a_range_pair: assert property (wide_drift_range != narrow_drift_range)
    else $error("drift range outputs disagree");
  a_det_enable: assert property (det_one_enable != det_one_disable)
    else $error("detector enable not inverse of disable");
  a_ref_saturate: assert property (out_ref_saturated == (out_ref_code[7:0] >= 8'hfa))
    else $error("reference saturation flag wrong");
  a_gain_stage: assert property (gain_high_second == !gain_code[4])
    else $error("second stage gain flag wrong");
  a_filter_flag: assert property (filter_enable == (filter_setting != 2'h0))
    else $error("filter enable flag wrong");
  a_conflict_flag: assert property (config_conflict == ((sample_rate_bit &&
    !temp_sensor_select) || gain_code[3:0] > 4'hc))
    else $error("conflict flag wrong");

  // main scenarios
  c_write: cover property (!avs_waitrequest && avs_write);
  c_read: cover property (!avs_waitrequest && avs_read);
  c_conflict: cover property (config_conflict);
  c_saturate: cover property (out_ref_saturated);
endmodule : stc_config_map_sva

bind stc_config_map stc_config_map_sva #(.ADDR_W(ADDR_W)) u_sva (.*);

// [stc_config_map_tb.sv]
// testbench: register access and trim outputs of the configuration bank
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
  $display("Error at %0t: got %h exp %h", $time, (a), (b)); end end
module stc_config_map_tb;
  import stc_pkg::*;
  // ============================================================
  // signals
  logic        clk_sys = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rdq;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [1:0]  avs_response, rsp, det_one_hyst_code, det_two_hyst_code;
  logic [1:0]  filter_setting, supply_drive_setting;
  logic [8:0]  offset_drift_code, sens_drift_code, out_ref_code;
  logic [4:0]  det_one_thresh_code, det_two_thresh_code, gain_code;
  logic        avs_waitrequest, drift_range_bit, wide_drift_range, narrow_drift_range;
  logic        det_one_polarity, det_one_disable, det_one_enable, det_one_direction;
  logic        det_two_polarity, det_two_disable, det_two_enable, det_two_direction;
  logic        det_one_thresh_source, out_ref_saturated, gain_high_second, gnd_pin_enable;
  logic        input_swap, temp_sensor_select, filter_enable, sample_rate_bit, config_conflict;
  int          errors = 0, num_checks = 0;
  // register offsets and their writable masks
  logic [7:0]  offs [12] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a,
                             8'h0b, 8'h0c, 8'h0d, 8'h13};
  logic [7:0]  msks [12] = '{8'h01, 8'hff, 8'h01, 8'hff, 8'hff, 8'hff, 8'h8f, 8'h01,
                             8'hff, 8'h1f, 8'hff, 8'h01};

  always #5 clk_sys = ~clk_sys;

  stc_config_map DUT (.*);

  // ============================================================
  // bus tasks: hold the request until waitrequest is sampled low
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    @(posedge clk_sys);
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rdq = avs_readdata;
    rsp = avs_response;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : acc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, a, d, 4'h1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r);
    acc(1'b0, a, 8'h00, 4'hf);
    `CHK(rdq, {24'h0, e})
    `CHK(rsp, r)
  endtask : rd
  // outputs follow the store one cycle later
  task automatic st;
    @(posedge clk_sys);
    #1;
  endtask : st

  // ============================================================
  // scenarios
  task automatic t_reset;
    for (int i = 0; i < 12; i++) rd(offs[i], 8'h00, 2'b00);
    `CHK({offset_drift_code, sens_drift_code, out_ref_code}, 27'h0)
    `CHK({det_one_enable, det_two_enable, narrow_drift_range, gain_high_second}, 4'hf)
  endtask : t_reset
  // unassigned bits read back as zero, bad accesses are refused
  task automatic t_masks;
    for (int i = 0; i < 12; i++) begin
      wr(offs[i], 8'hff);
      rd(offs[i], msks[i], 2'b00);
    end
    acc(1'b1, 8'h04, 8'h00, 4'h0);
    rd(8'h04, 8'hff, 2'b00);
    rd(8'h30, 8'h00, 2'b10);
    wr(8'h20, 8'h00);
    rd(8'h20, 8'h05, 2'b00);
  endtask : t_masks
  task automatic t_fields;
    wr(8'h03, 8'h01); wr(8'h04, 8'h5a); wr(8'h05, 8'h00); wr(8'h06, 8'hff);
    wr(8'h13, 8'h01); wr(8'h07, 8'ha3); wr(8'h08, 8'h50); wr(8'h09, 8'h8e);
    wr(8'h0a, 8'h01); wr(8'h0b, 8'hfa); wr(8'h0c, 8'h1c); wr(8'h0d, 8'hb5);
    st;
    `CHK(offset_drift_code, 9'h15a)
    `CHK(sens_drift_code, 9'h0ff)
    `CHK({drift_range_bit, wide_drift_range, narrow_drift_range}, 3'b110)
    `CHK({det_one_polarity, det_one_disable, det_one_enable, det_one_direction}, 4'hb)
    `CHK({det_two_polarity, det_two_disable, det_two_enable, det_two_direction}, 4'h4)
    `CHK({det_one_thresh_code, det_two_thresh_code}, 10'h070)
    `CHK({det_one_thresh_source, det_one_hyst_code, det_two_hyst_code}, 5'h1b)
    `CHK({out_ref_code, out_ref_saturated}, 10'h3f5)
    `CHK({gain_code, gain_high_second}, 6'h38)
    `CHK({gnd_pin_enable, input_swap, temp_sensor_select, filter_setting,
          supply_drive_setting, sample_rate_bit}, 8'hb5)
    wr(8'h0b, 8'hf9);
    st;
    `CHK(out_ref_saturated, 1'b0)
  endtask : t_fields
  // every filter and supply code, then the forbidden combinations
  task automatic t_codes;
    for (int i = 0; i < 4; i++) begin
      wr(8'h0d, {3'h0, 2'(i), 2'(i), 1'b0});
      st;
      `CHK({filter_enable, filter_setting}, {i != 0, 2'(i)})
      `CHK(supply_drive_setting, 2'(i))
    end
    wr(8'h0c, 8'h0c); wr(8'h0d, 8'h01); st;
    `CHK(config_conflict, 1'b1)
    wr(8'h0d, 8'h21); st;
    `CHK(config_conflict, 1'b0)
    wr(8'h0c, 8'h0d); st;
    `CHK(config_conflict, 1'b1)
    wr(8'h13, 8'h00);
    wr(8'h0c, 8'h10);
    st;
    `CHK({narrow_drift_range, gain_high_second}, 2'b10)
  endtask : t_codes
  // mid-run reset returns stores and trims to their defaults
  task automatic t_rerst;
    wr(8'h07, 8'h40);
    wr(8'h0d, 8'hb5);
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    rd(8'h07, 8'h00, 2'b00);
    `CHK({det_one_enable, det_one_disable, gnd_pin_enable, sample_rate_bit}, 4'h8)
  endtask : t_rerst

  // ============================================================
  // verdict and run control
  task automatic results;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results
  // a hung handshake ends here; the full run needs a few hundred cycles
  initial begin
    #100000;
    errors++;
    results();
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset();
    t_masks();
    t_fields();
    t_codes();
    t_rerst();
    results();
  end
endmodule : stc_config_map_tb

// [stc_pkg.sv]
// package: register map, field layout and codes of the sensor trim configuration bank
package stc_pkg;

  // ============================================================
  // register word offsets (each register one aligned 32-bit word)
  localparam logic [7:0] OFF_OFFSET_DRIFT_A = 8'h03;
  localparam logic [7:0] OFF_OFFSET_DRIFT_B = 8'h04;
  localparam logic [7:0] OFF_SENS_DRIFT_A   = 8'h05;
  localparam logic [7:0] OFF_SENS_DRIFT_B   = 8'h06;
  localparam logic [7:0] OFF_DET_ONE_SETUP  = 8'h07;
  localparam logic [7:0] OFF_DET_TWO_SETUP  = 8'h08;
  localparam logic [7:0] OFF_DET_HYST       = 8'h09;
  localparam logic [7:0] OFF_OUT_REF_HIGH   = 8'h0a;
  localparam logic [7:0] OFF_OUT_REF_LOW    = 8'h0b;
  localparam logic [7:0] OFF_GAIN_SELECT    = 8'h0c;
  localparam logic [7:0] OFF_MEAS_SETUP     = 8'h0d;
  localparam logic [7:0] OFF_DRIFT_RANGE    = 8'h13;
  localparam logic [7:0] OFF_STATUS         = 8'h20;

  // ============================================================
  // writable bit masks of each register
  localparam logic [7:0] MASK_BIT0    = 8'h01;
  localparam logic [7:0] MASK_FULL    = 8'hff;
  localparam logic [7:0] MASK_HYST    = 8'h8f;
  localparam logic [7:0] MASK_GAIN    = 8'h1f;

  // ============================================================
  // reset value of every stored field
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ============================================================
  // field positions
  localparam int DET_POL_BIT  = 7;
  localparam int DET_DIS_BIT  = 6;
  localparam int DET_DIR_BIT  = 5;
  localparam int HYST_SRC_BIT = 7;
  localparam int GAIN_G2_BIT  = 4;
  localparam int MEAS_GND_BIT = 7;
  localparam int MEAS_SWP_BIT = 6;
  localparam int MEAS_TMP_BIT = 5;
  localparam int MEAS_SF_BIT  = 0;

  // ============================================================
  // codes
  localparam logic [3:0] GAIN_CODE_MAX  = 4'hc;
  localparam logic [1:0] FILTER_OFF     = 2'h0;
  localparam logic       TEMP_EXTERNAL  = 1'b0;
  localparam logic       RATE_1KHZ      = 1'b1;

  // ============================================================
  // bus response codes and reference saturation code
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
  localparam logic [7:0] REF_SAT_CODE = 8'hfa;

  // status bits
  localparam int ST_GAIN_BAD = 0;
  localparam int ST_RATE_BAD = 1;
  localparam int ST_FILT_ON  = 2;

endpackage : stc_pkg
